//--- hw/uamc_dev.sv
/*
  Device end: alarm detection, sticky alarm registers, input mux and
  link mode decode, as an AHB-Lite slave with zero wait states.
  Assumes channel clock phases, lane FIFO flags and the power-down pin
  arrive asynchronously; the receiver consumes the link outputs.
*/
`timescale 1ns/1ns
`include "uamc_cfg.svh"
module uamc_dev (
  input  wire logic                    REF_CLK_I,
  input  wire logic                    RST_I,
  uamc_ahb_if.slave                    BUS,
  input  wire logic                    CHAN_A_CLK_PHASE_I,
  input  wire logic                    CHAN_B_CLK_PHASE_I,
  input  wire logic [`UAMC_LANES-1:0]  LANE_FIFO_OVF_I,
  input  wire logic [`UAMC_LANES-1:0]  LANE_FIFO_UNF_I,
  input  wire logic                    POWER_DOWN_PIN_I,
  output logic                         CAL_STATUS_PIN_O,
  output logic                         LINK_RESET_O,
  output logic                         SERDES_POWER_DOWN_O,
  output logic                         LINK_CLK_GATE_O,
  output logic                         INTERLEAVE_O,
  output logic                         DUAL_INPUT_IL_O,
  output logic                         CHAN_A_SRC_O,
  output logic                         CHAN_B_SRC_O,
  output logic                         CHAN_A_PD_O,
  output logic                         CHAN_B_PD_O,
  output logic [4:0]                   BITS_PER_CLK_X4_O,
  output logic                         ENC_64B66B_O,
  output logic                         ILAS_EN_O,
  output logic [8:0]                   FRAMES_PER_MF_O,
  output logic [7:0]                   MB_PER_EMB_O
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 3 + 2 * `UAMC_LANES;
  logic [SW-1:0] sy1;
  logic [SW-1:0] sy2;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      sy1 <= '0;
      sy2 <= '0;
    end else begin
      sy1 <= {POWER_DOWN_PIN_I, CHAN_A_CLK_PHASE_I, CHAN_B_CLK_PHASE_I,
              LANE_FIFO_OVF_I, LANE_FIFO_UNF_I};
      sy2 <= sy1;
    end
  end
  wire                   pin_pd = sy2[SW-1];
  wire                   ph_a   = sy2[SW-2];
  wire                   ph_b   = sy2[SW-3];
  wire [`UAMC_LANES-1:0] lane_ev = sy2[2*`UAMC_LANES-1:`UAMC_LANES] | sy2[`UAMC_LANES-1:0];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [`UAMC_CTRL_W-1:0] ctrl;
  logic [4:0]              mode_code;
  logic [7:0]              km1;
  logic [1:0]              sel_eff;
  logic                    swap_eff;
  logic                    clock_upset_alarm;
  logic                    fifo_upset_alarm;
  logic [`UAMC_LANES-1:0]  lane_alm;
  logic                    gpd_q;
  logic                    wr_pend;
  logic [7:0]              wr_addr;

  function automatic uamc_pkg::uamc_mode_t dec(input logic [4:0] c);
    uamc_pkg::uamc_mode_t m;
    m = '0;
    m.known = 1'b1;
    unique case (c)
      5'h00: begin m.des = 1'b1; m.r_x4 = 5'h10; end
      5'h01: begin m.des = 1'b1; m.r_x4 = 5'h08; end
      5'h02: m.r_x4 = 5'h10;
      5'h03: m.r_x4 = 5'h08;
      5'h05: begin m.des = 1'b1; m.r_x4 = 5'h0A; end
      5'h06: begin m.des = 1'b1; m.r_x4 = 5'h05; end
      default: m.known = 1'b0;
    endcase
    return m;
  endfunction : dec

  uamc_pkg::uamc_mode_t md;
  assign md = dec(mode_code);

  wire gpd_now  = ctrl[`UAMC_CTRL_GPD] | pin_pd;
  wire both_on  = ~ctrl[`UAMC_CTRL_PDA] & ~ctrl[`UAMC_CTRL_PDB] & ~gpd_now;
  wire clk_diff = both_on & (ph_a != ph_b);
  wire pd_exit  = gpd_q & ~gpd_now;

  function automatic logic [31:0] rd(input logic [7:0] a);
    logic [31:0] v;
    v = '0;
    unique case (a)
      `UAMC_OFF_CTRL:   v[`UAMC_CTRL_W-1:0] = ctrl;
      `UAMC_OFF_MODE:   v = {16'h0000, km1, 3'h0, mode_code};
      `UAMC_OFF_ALARM:  v = {lane_alm, 14'h0000, fifo_upset_alarm, clock_upset_alarm};
      `UAMC_OFF_STATUS: v = {19'h00000, BITS_PER_CLK_X4_O, 3'h0, md.known,
                             LINK_RESET_O, ILAS_EN_O, ENC_64B66B_O, INTERLEAVE_O};
      default:          v = '0;
    endcase
    return v;
  endfunction : rd

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait, always OKAY, read data staged at address phase
  // ----------------------------------------------------------------
  wire take = BUS.hsel & BUS.htrans[1] & BUS.hready;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
      BUS.hrdata <= 32'h00000000;
      BUS.hready <= 1'b1;
      BUS.hresp  <= 1'b0;
    end else begin
      wr_pend    <= take & BUS.hwrite;
      wr_addr    <= BUS.haddr[7:0];
      BUS.hready <= 1'b1;
      BUS.hresp  <= 1'b0;
      if (take & ~BUS.hwrite) begin
        BUS.hrdata <= rd(BUS.haddr[7:0]);
      end
    end
  end
  wire w_ctrl  = wr_pend & (wr_addr == `UAMC_OFF_CTRL);
  wire w_mode  = wr_pend & (wr_addr == `UAMC_OFF_MODE);
  wire w_alarm = wr_pend & (wr_addr == `UAMC_OFF_ALARM);
  wire w_cal   = wr_pend & (wr_addr == `UAMC_OFF_CAL) & BUS.hwdata[0];

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ctrl      <= `UAMC_CTRL_RST;
      mode_code <= 5'h00;
      km1       <= `UAMC_KM1_RST;
    end else begin
      if (w_ctrl) begin
        ctrl <= BUS.hwdata[`UAMC_CTRL_W-1:0];
      end
      if (w_mode) begin
        mode_code <= BUS.hwdata[4:0];
        km1       <= BUS.hwdata[`UAMC_KM1_LO+7:`UAMC_KM1_LO];
      end
    end
  end

  // New input selection only takes hold on a calibration strobe
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      sel_eff  <= `UAMC_SEL_A;
      swap_eff <= 1'b0;
    end else if (w_cal) begin
      sel_eff  <= ctrl[`UAMC_CTRL_SEL_HI:`UAMC_CTRL_SEL_LO];
      swap_eff <= ctrl[`UAMC_CTRL_SWAP];
    end
  end

  // ----------------------------------------------------------------
  // Sticky alarms: set wins over a clearing write
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      gpd_q    <= 1'b0;
      clock_upset_alarm  <= 1'b0;
      fifo_upset_alarm <= 1'b0;
      lane_alm <= '0;
    end else begin
      gpd_q    <= gpd_now;
      clock_upset_alarm  <= (clock_upset_alarm & ~(w_alarm & BUS.hwdata[`UAMC_ALM_CLK]))
                  | clk_diff | pd_exit;
      fifo_upset_alarm <= (fifo_upset_alarm & ~(w_alarm & BUS.hwdata[`UAMC_ALM_FIFO]))
                  | (|lane_ev);
      lane_alm <= (lane_alm & ~({`UAMC_LANES{w_alarm}}
                  & BUS.hwdata[`UAMC_ALM_LANE_LO+`UAMC_LANES-1:`UAMC_ALM_LANE_LO]))
                  | lane_ev;
    end
  end

  // ----------------------------------------------------------------
  // Link control: reinit holds reset for as long as a lane keeps failing
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      LINK_RESET_O        <= 1'b1;
      SERDES_POWER_DOWN_O <= 1'b1;
      LINK_CLK_GATE_O     <= 1'b1;
      CAL_STATUS_PIN_O    <= 1'b0;
    end else begin
      LINK_RESET_O        <= ~ctrl[`UAMC_CTRL_EN]
                             | (ctrl[`UAMC_CTRL_REINIT] & (|lane_ev));
      SERDES_POWER_DOWN_O <= ~ctrl[`UAMC_CTRL_EN];
      LINK_CLK_GATE_O     <= ~ctrl[`UAMC_CTRL_EN];
      CAL_STATUS_PIN_O    <= ctrl[`UAMC_CTRL_CSSEL] & clock_upset_alarm;
    end
  end

  // ----------------------------------------------------------------
  // Transport parameters derived from the link mode code
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      INTERLEAVE_O      <= 1'b0;
      BITS_PER_CLK_X4_O <= 5'h00;
      ENC_64B66B_O      <= 1'b0;
      ILAS_EN_O         <= 1'b0;
      FRAMES_PER_MF_O   <= 9'h000;
      MB_PER_EMB_O      <= `UAMC_E_FIXED;
    end else begin
      INTERLEAVE_O      <= md.des;
      BITS_PER_CLK_X4_O <= md.r_x4;
      ENC_64B66B_O      <= md.enc64;
      ILAS_EN_O         <= ~md.enc64;
      FRAMES_PER_MF_O   <= md.enc64 ? 9'h000 : ({1'b0, km1} + 9'h001);
      MB_PER_EMB_O      <= `UAMC_E_FIXED;
    end
  end

  // ----------------------------------------------------------------
  // Channel routing and power: source 0 is input A, 1 is input B
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      CHAN_A_SRC_O    <= 1'b0;
      CHAN_B_SRC_O    <= 1'b1;
      DUAL_INPUT_IL_O <= 1'b0;
      CHAN_A_PD_O     <= 1'b1;
      CHAN_B_PD_O     <= 1'b1;
    end else if (md.des) begin
      // Interleaving needs both halves, so the per-channel power-down bits are ignored here
      CHAN_A_PD_O     <= gpd_now;
      CHAN_B_PD_O     <= gpd_now;
      DUAL_INPUT_IL_O <= (sel_eff == `UAMC_SEL_BOTH);
      CHAN_A_SRC_O    <= (sel_eff == `UAMC_SEL_B);
      CHAN_B_SRC_O    <= (sel_eff != `UAMC_SEL_A);
    end else begin
      CHAN_A_PD_O     <= gpd_now | ctrl[`UAMC_CTRL_PDA];
      CHAN_B_PD_O     <= gpd_now | ctrl[`UAMC_CTRL_PDB];
      DUAL_INPUT_IL_O <= 1'b0;
      CHAN_A_SRC_O    <= swap_eff;
      CHAN_B_SRC_O    <= ~swap_eff;
    end
  end

endmodule : uamc_dev

//--- shared/uamc_cfg.svh
/*
  Offsets, field positions, reset values and counts of the upset, alarm and
  mode control block. Assumes a 32-bit AHB-Lite register window, byte addressed.
*/
`ifndef UAMC_CFG_SVH
`define UAMC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define UAMC_OFF_CTRL    8'h00
`define UAMC_OFF_MODE    8'h04
`define UAMC_OFF_ALARM   8'h08
`define UAMC_OFF_STATUS  8'h0C
`define UAMC_OFF_CAL     8'h10

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define UAMC_CTRL_EN     0
`define UAMC_CTRL_PDA    1
`define UAMC_CTRL_PDB    2
`define UAMC_CTRL_GPD    3
`define UAMC_CTRL_REINIT 4
`define UAMC_CTRL_SWAP   5
`define UAMC_CTRL_SEL_LO 6
`define UAMC_CTRL_SEL_HI 7
`define UAMC_CTRL_CSSEL  8
`define UAMC_CTRL_W      9
`define UAMC_CTRL_RST    9'h000

// ----------------------------------------------------------------
// Mode, alarm and status fields
// ----------------------------------------------------------------
`define UAMC_KM1_LO      8
`define UAMC_KM1_RST     8'h1F
`define UAMC_ALM_CLK     0
`define UAMC_ALM_FIFO    1
`define UAMC_ALM_LANE_LO 16
`define UAMC_LANES       16
`define UAMC_SEL_A       2'h0
`define UAMC_SEL_B       2'h1
`define UAMC_SEL_BOTH    2'h2
`define UAMC_E_FIXED     8'h01
`define UAMC_HSIZE_WORD  3'h2
`define UAMC_HTRANS_IDLE 2'h0
`define UAMC_HTRANS_NSEQ 2'h2

`endif

//--- shared/uamc_pkg.sv
/*
  Types of the upset, alarm and mode control block.
  Assumes uamc_cfg.svh for all figures.
*/
package uamc_pkg;

  // Decoded link mode: r_x4 is bits per clock times four
  typedef struct packed {
    logic       known;
    logic       des;
    logic       enc64;
    logic [4:0] r_x4;
  } uamc_mode_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_ADDR = 3'b010,
    H_DATA = 3'b100
  } uamc_hstate_t;

endpackage : uamc_pkg

//--- shared/uamc_ahb_if.sv
/*
  AHB-Lite connection between host register sequencer and device control.
  Assumes one master, one slave, shared clock and reset outside.
*/
`timescale 1ns/1ns
interface uamc_ahb_if;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;

  modport master (output hsel, haddr, htrans, hwrite, hsize, hwdata,
                  input  hrdata, hready, hresp);
  modport slave  (input  hsel, haddr, htrans, hwrite, hsize, hwdata,
                  output hrdata, hready, hresp);
endinterface : uamc_ahb_if

//--- hw/uamc_host.sv
/*
  Host end: AHB-Lite master that runs user register commands and the
  housekeeping writes the device expects (arm sequence, calibration after
  a mux change, alarm clear after a control write clears global power-down).
  Assumes a single slave whose hready may stall it.
*/
`timescale 1ns/1ns
`include "uamc_cfg.svh"
module uamc_host (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  uamc_ahb_if.master       BUS,
  input  wire logic        CMD_VALID_I,
  input  wire logic        CMD_WRITE_I,
  input  wire logic [7:0]  CMD_ADDR_I,
  input  wire logic [31:0] CMD_WDATA_I,
  input  wire logic        ARM_I,
  output logic             CMD_READY_O,
  output logic             DONE_O,
  output logic [31:0]      RDATA_O
);

  uamc_pkg::uamc_hstate_t  state;
  logic [1:0]              arm;
  logic                    cal_pend;
  logic                    clr_pend;
  logic                    user_q;
  logic [31:0]             wdata_q;
  logic [`UAMC_CTRL_W-1:0] shadow;

  logic                    op_go;
  logic                    op_wr;
  logic                    op_user;
  logic [7:0]              op_addr;
  logic [31:0]             op_data;

  localparam logic [`UAMC_CTRL_W-1:0] ARM_OFF =
    `UAMC_CTRL_W'((1 << `UAMC_CTRL_EN) | (1 << `UAMC_CTRL_PDA) | (1 << `UAMC_CTRL_PDB));
  localparam logic [`UAMC_CTRL_W-1:0] EN_BIT = `UAMC_CTRL_W'(1 << `UAMC_CTRL_EN);
  localparam logic [`UAMC_CTRL_W-1:0] MUX_BITS =
    `UAMC_CTRL_W'((3 << `UAMC_CTRL_SEL_LO) | (1 << `UAMC_CTRL_SWAP));

  // ----------------------------------------------------------------
  // Next operation: housekeeping always ahead of user commands
  // ----------------------------------------------------------------
  always_comb begin
    op_go   = 1'b1;
    op_wr   = 1'b1;
    op_user = 1'b0;
    op_addr = `UAMC_OFF_CTRL;
    op_data = '0;
    if (arm == 2'h1) begin
      op_data[`UAMC_CTRL_W-1:0] = shadow & ~ARM_OFF;
    end else if (arm == 2'h2) begin
      op_data[`UAMC_CTRL_W-1:0] = (shadow & ~ARM_OFF) | EN_BIT;
    end else if (arm == 2'h3 || clr_pend) begin
      op_addr = `UAMC_OFF_ALARM;
      op_data[`UAMC_ALM_CLK] = 1'b1;
    end else if (cal_pend) begin
      op_addr = `UAMC_OFF_CAL;
      op_data[0] = 1'b1;
    end else begin
      op_go   = CMD_READY_O & CMD_VALID_I & ~ARM_I;
      op_wr   = CMD_WRITE_I;
      op_user = 1'b1;
      op_addr = CMD_ADDR_I;
      op_data = CMD_WDATA_I;
    end
  end

  wire user_ctrl_wr = op_user & op_wr & (op_addr == `UAMC_OFF_CTRL);

  // ----------------------------------------------------------------
  // Housekeeping bookkeeping, updated when an operation launches or an arm sequence starts
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      arm      <= 2'h0;
      cal_pend <= 1'b0;
      clr_pend <= 1'b0;
      shadow   <= `UAMC_CTRL_RST;
    end else if (state == uamc_pkg::H_IDLE) begin
      if (arm == 2'h0 && !cal_pend && !clr_pend && CMD_READY_O && ARM_I) begin
        arm <= 2'h1;
      end else if (arm != 2'h0) begin
        arm <= arm + 2'h1;
        if (arm != 2'h3) begin
          shadow <= op_data[`UAMC_CTRL_W-1:0];
        end
      end else if (clr_pend) begin
        clr_pend <= 1'b0;
      end else if (cal_pend) begin
        cal_pend <= 1'b0;
      end else if (op_go && user_ctrl_wr) begin
        shadow   <= op_data[`UAMC_CTRL_W-1:0];
        cal_pend <= |((shadow ^ op_data[`UAMC_CTRL_W-1:0]) & MUX_BITS);
        clr_pend <= shadow[`UAMC_CTRL_GPD] & ~op_data[`UAMC_CTRL_GPD];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus sequencer
  // ----------------------------------------------------------------
  wire arm_start = arm == 2'h0 && !cal_pend && !clr_pend && CMD_READY_O && ARM_I;
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state       <= uamc_pkg::H_IDLE;
      user_q      <= 1'b0;
      wdata_q     <= 32'h00000000;
      CMD_READY_O <= 1'b1;
      DONE_O      <= 1'b0;
      RDATA_O     <= 32'h00000000;
      BUS.hsel    <= 1'b0;
      BUS.haddr   <= 32'h00000000;
      BUS.htrans  <= `UAMC_HTRANS_IDLE;
      BUS.hwrite  <= 1'b0;
      BUS.hsize   <= `UAMC_HSIZE_WORD;
      BUS.hwdata  <= 32'h00000000;
    end else begin
      DONE_O <= 1'b0;
      unique case (state)
        uamc_pkg::H_IDLE: begin
          if (arm_start) begin
            CMD_READY_O <= 1'b0;
          end else if (op_go) begin
            CMD_READY_O <= 1'b0;
            user_q      <= op_user;
            wdata_q     <= op_data;
            BUS.hsel    <= 1'b1;
            BUS.haddr   <= {24'h000000, op_addr};
            BUS.htrans  <= `UAMC_HTRANS_NSEQ;
            BUS.hwrite  <= op_wr;
            state       <= uamc_pkg::H_ADDR;
          end
        end
        uamc_pkg::H_ADDR: begin
          if (BUS.hready) begin
            BUS.hsel   <= 1'b0;
            BUS.htrans <= `UAMC_HTRANS_IDLE;
            BUS.hwdata <= wdata_q;
            state      <= uamc_pkg::H_DATA;
          end
        end
        uamc_pkg::H_DATA: begin
          if (BUS.hready) begin
            state       <= uamc_pkg::H_IDLE;
            CMD_READY_O <= arm == 2'h0 && !cal_pend && !clr_pend;
            if (user_q) begin
              DONE_O  <= 1'b1;
              RDATA_O <= BUS.hrdata;
            end
          end
        end
      endcase
    end
  end

endmodule : uamc_host

//--- tb/uamc_assertions.sv
/*
  Concurrent checks on the host-to-device bus and the device's link-side outputs.
  Assumes one clock domain, a synchronous active-high reset and instantiation beside the interface.
*/
`timescale 1ns/1ns
`include "uamc_cfg.svh"
module uamc_assertions (
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hrdata,
  input wire logic        hready,
  input wire logic        hresp,
  input wire logic        SERDES_POWER_DOWN_O,
  input wire logic        LINK_CLK_GATE_O,
  input wire logic        LINK_RESET_O,
  input wire logic        ILAS_EN_O,
  input wire logic        ENC_64B66B_O,
  input wire logic [8:0]  FRAMES_PER_MF_O,
  input wire logic [7:0]  MB_PER_EMB_O,
  input wire logic        INTERLEAVE_O,
  input wire logic        DUAL_INPUT_IL_O,
  input wire logic        CHAN_A_SRC_O,
  input wire logic        CHAN_B_SRC_O,
  input wire logic        CAL_STATUS_PIN_O
);
  // ----------------------------------------------------------------
  // Bus protocol
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  wire logic taken = hsel && htrans == `UAMC_HTRANS_NSEQ && hready;
  bus_okay_a: assert property (hready && !hresp) else $error("slave stalled or errored");
  one_addr_a: assert property (taken |=> htrans == `UAMC_HTRANS_IDLE) else $error("address phase not released");
  word_size_a: assert property (taken |-> hsize == `UAMC_HSIZE_WORD) else $error("transfer not a word");
  // Read data must hold so a slow master still sees it
  rdata_hold_a: assert property (!(taken && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
  // ----------------------------------------------------------------
  // Link outputs
  // ----------------------------------------------------------------
  link_off_a: assert property (SERDES_POWER_DOWN_O == LINK_CLK_GATE_O
    && (!SERDES_POWER_DOWN_O || LINK_RESET_O)) else $error("link off outputs disagree");
  ilas_enc_a: assert property (!$past(RST_I) |-> ILAS_EN_O != ENC_64B66B_O)
    else $error("alignment sequence flag wrong");
  frames_set_a: assert property (!$past(RST_I) && !ENC_64B66B_O |-> FRAMES_PER_MF_O != 9'h000)
    else $error("frame count empty");
  mb_fixed_a: assert property (MB_PER_EMB_O == 8'h01) else $error("multiblock count not one");
  // Guard one cycle after a mode change; mode and sources update on the same edge
  dual_src_a: assert property (!INTERLEAVE_O && $past(!INTERLEAVE_O) && !$past(RST_I)
    |-> CHAN_A_SRC_O != CHAN_B_SRC_O) else $error("dual channels share an input");
  both_in_a: assert property (DUAL_INPUT_IL_O && $past(DUAL_INPUT_IL_O)
    |-> INTERLEAVE_O && !CHAN_A_SRC_O && CHAN_B_SRC_O) else $error("dual-input interleave wrong");
  read_c: cover property (taken && !hwrite);
  pin_c: cover property (CAL_STATUS_PIN_O);
  dual_il_c: cover property (DUAL_INPUT_IL_O);
endmodule : uamc_assertions

//--- tb/tb.sv
/*
  Self-checking bench: host and device joined by the bus, driven from the command port and device pins.
  Assumes the design files and the shared folder on the include path.
*/
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // Stimulus and bookkeeping
  // ----------------------------------------------------------------
  logic        REF_CLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic        cmd_valid = 1'b0, cmd_write = 1'b0, arm = 1'b0, phase_a = 1'b0, glitch = 1'b0, pd_pin = 1'b0;
  logic [7:0]  cmd_addr = 8'h00, km1;
  logic [31:0] cmd_wdata = 32'h0, rdata;
  logic [15:0] ovf = 16'h0, unf = 16'h0, lfsr_state = 16'hAB7B;
  logic [3:0]  lane;
  logic [63:0] note, exp_q[$];
  logic [8:0]  frames;
  logic [7:0]  mb;
  logic        cmd_ready, done, cal_pin, link_rst, serdes_pd, clk_gate, il, dual_il, src_a, src_b;
  logic        pd_a, pd_b, enc64, ilas;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  localparam logic [4:0] RATIO [8] = '{5'h10, 5'h08, 5'h10, 5'h08, 5'h00, 5'h0A, 5'h05, 5'h00};
  uamc_ahb_if bus_if();
  uamc_host i_uamc_host (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .BUS(bus_if), .CMD_VALID_I(cmd_valid),
    .CMD_WRITE_I(cmd_write), .CMD_ADDR_I(cmd_addr), .CMD_WDATA_I(cmd_wdata), .ARM_I(arm),
    .CMD_READY_O(cmd_ready), .DONE_O(done), .RDATA_O(rdata));
  uamc_dev i_uamc_dev (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .BUS(bus_if), .CHAN_A_CLK_PHASE_I(phase_a),
    .CHAN_B_CLK_PHASE_I(phase_a ^ glitch), .LANE_FIFO_OVF_I(ovf), .LANE_FIFO_UNF_I(unf),
    .POWER_DOWN_PIN_I(pd_pin), .CAL_STATUS_PIN_O(cal_pin), .LINK_RESET_O(link_rst),
    .SERDES_POWER_DOWN_O(serdes_pd), .LINK_CLK_GATE_O(clk_gate), .INTERLEAVE_O(il),
    .DUAL_INPUT_IL_O(dual_il), .CHAN_A_SRC_O(src_a), .CHAN_B_SRC_O(src_b), .CHAN_A_PD_O(pd_a),
    .CHAN_B_PD_O(pd_b), .BITS_PER_CLK_X4_O(), .ENC_64B66B_O(enc64), .ILAS_EN_O(ilas),
    .FRAMES_PER_MF_O(frames), .MB_PER_EMB_O(mb));
  uamc_assertions i_uamc_assertions (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I), .hsel(bus_if.hsel),
    .htrans(bus_if.htrans), .hwrite(bus_if.hwrite), .hsize(bus_if.hsize), .hrdata(bus_if.hrdata),
    .hready(bus_if.hready), .hresp(bus_if.hresp), .SERDES_POWER_DOWN_O(serdes_pd),
    .LINK_CLK_GATE_O(clk_gate), .LINK_RESET_O(link_rst), .ILAS_EN_O(ilas), .ENC_64B66B_O(enc64),
    .FRAMES_PER_MF_O(frames), .MB_PER_EMB_O(mb), .INTERLEAVE_O(il), .DUAL_INPUT_IL_O(dual_il),
    .CHAN_A_SRC_O(src_a), .CHAN_B_SRC_O(src_b), .CAL_STATUS_PIN_O(cal_pin));
  always #25 REF_CLK_I = ~REF_CLK_I;
  always @(posedge REF_CLK_I) phase_a <= ~phase_a;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  task test_done;
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Waits out any housekeeping writes too, so outputs have settled on return
  task cmd(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic [31:0] mask);
    exp_q.push_back({mask, data & mask});
    cmd_write <= wr;
    cmd_addr  <= addr;
    cmd_wdata <= data;
    cmd_valid <= 1'b1;
    @(posedge REF_CLK_I);
    while (!cmd_ready) @(posedge REF_CLK_I);
    cmd_valid <= 1'b0;
    @(posedge REF_CLK_I);
    while (!done) @(posedge REF_CLK_I);
    while (!cmd_ready) @(posedge REF_CLK_I);
    @(posedge REF_CLK_I);
  endtask : cmd
  task wr(input logic [7:0] addr, input logic [31:0] data);
    cmd(1'b1, addr, data, 32'h0);
  endtask : wr
  task arm_seq;
    arm <= 1'b1;
    @(posedge REF_CLK_I);
    while (!cmd_ready) @(posedge REF_CLK_I);
    arm <= 1'b0;
    @(posedge REF_CLK_I);
    while (!cmd_ready) @(posedge REF_CLK_I);
    @(posedge REF_CLK_I);
  endtask : arm_seq
  task upset;
    glitch <= 1'b1;
    @(posedge REF_CLK_I);
    glitch <= 1'b0;
    repeat (4) @(posedge REF_CLK_I);
  endtask : upset
  // ----------------------------------------------------------------
  // Result monitor and hang guard
  // ----------------------------------------------------------------
  always @(posedge REF_CLK_I) begin
    if (!RST_I && done) begin
      note = exp_q.pop_front();
      check(rdata & note[63:32], note[31:0]);
    end
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      $display("Error at %0t: timeout", $time);
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge REF_CLK_I);
    RST_I <= 1'b0;
    @(posedge REF_CLK_I);
    cmd(0, 8'h00, 32'h0, 32'hFFFFFFFF);
    cmd(0, 8'h04, 32'h1F00, 32'hFFFFFFFF);
    cmd(0, 8'h0C, 32'h101D, 32'h1F1F);
    wr(8'h14, 32'h0000FFFF);
    cmd(0, 8'h14, 32'h0, 32'hFFFFFFFF);
    for (int c = 0; c < 8; c++) begin
      lfsr_state = lfsr_next(lfsr_state);
      km1 = lfsr_state[7:0];
      wr(8'h04, {16'h0000, km1, 3'h0, c[4:0]});
      cmd(0, 8'h0C, {19'h0, RATIO[c], 3'h0, 8'h6F >> c & 8'h01 ? 5'h1C : 5'h0C} | (8'h63 >> c & 8'h01), 32'h1F1F);
      check({23'h0, frames}, {24'h0, km1} + 32'h1);
    end
    wr(8'h00, 32'h100);
    upset();
    check({31'h0, cal_pin}, 32'h1);
    cmd(0, 8'h08, 32'h1, 32'h1);
    wr(8'h08, 32'h0);
    cmd(0, 8'h08, 32'h1, 32'h1);
    arm_seq();
    cmd(0, 8'h08, 32'h0, 32'h1);
    cmd(0, 8'h00, 32'h101, 32'h1FF);
    check({30'h0, serdes_pd, cal_pin}, 32'h0);
    wr(8'h04, 32'h1F02);
    wr(8'h00, 32'h103);
    upset();
    cmd(0, 8'h08, 32'h0, 32'h1);
    check({28'h0, pd_a, pd_b, src_a, src_b}, 32'h9);
    wr(8'h00, 32'h121);
    check({30'h0, src_a, src_b}, 32'h2);
    wr(8'h04, 32'h1F00);
    wr(8'h00, 32'h181);
    check({28'h0, il, dual_il, src_a, src_b}, 32'hD);
    wr(8'h00, 32'h141);
    check({28'h0, il, dual_il, src_a, src_b}, 32'hB);
    wr(8'h00, 32'h111);
    lane = lfsr_state[3:0];
    ovf[lane] <= 1'b1;
    repeat (4) @(posedge REF_CLK_I);
    check({31'h0, link_rst}, 32'h1);
    ovf <= 16'h0;
    unf[lane ^ 4'h5] <= 1'b1;
    repeat (4) @(posedge REF_CLK_I);
    unf <= 16'h0;
    repeat (4) @(posedge REF_CLK_I);
    check({31'h0, link_rst}, 32'h0);
    cmd(0, 8'h08, (32'h10000 << lane) | (32'h10000 << (lane ^ 4'h5)) | 32'h2, 32'hFFFF0002);
    wr(8'h08, 32'hFFFF0002);
    cmd(0, 8'h08, 32'h0, 32'hFFFF0002);
    wr(8'h00, 32'h119);
    wr(8'h00, 32'h111);
    cmd(0, 8'h08, 32'h0, 32'h1);
    pd_pin <= 1'b1;
    repeat (4) @(posedge REF_CLK_I);
    pd_pin <= 1'b0;
    repeat (4) @(posedge REF_CLK_I);
    cmd(0, 8'h08, 32'h1, 32'h1);
    test_done();
  end
endmodule : tb
